// ### sim/dcache_lockdown_tb.sv
// self-checking testbench for the data cache lockdown and maintenance block
`timescale 1ns/1ps
module dcache_lockdown_tb;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cp_valid_in = 1'b0;
   logic [3:0] cp_crn_in = 4'h0;
   logic [3:0] cp_crm_in = 4'h0;
   logic [2:0] cp_op2_in = 3'h0;
   logic [31:0] cp_data_in = 32'h0000_0000;
   logic acc_valid_in = 1'b0;
   logic acc_write_in = 1'b0;
   logic acc_cachable_in = 1'b0;
   logic [31:0] acc_addr_in = 32'h0000_0000;
   logic [31:0] acc_wdata_in = 32'h0000_0000;
   logic fill_valid_in = 1'b0;
   logic [31:0] fill_data_in = 32'h0000_0000;
   logic wb_ready_in = 1'b0;
   logic cp_ready_out, acc_done_out, acc_hit_out, fill_req_out, wb_valid_out;
   logic icache_invalidate_out, cache_enabled_out, round_robin_out;
   logic [31:0] acc_rdata_out, fill_addr_out, wb_addr_out, wb_data_out;
   int n_fail = 0;
   int check_count = 0;
   int fill_words = 0, wb_words = 0, ic_pulses = 0, fill_cnt = 0, got_fill, n;
   logic [31:0] fill_line, wb_line, got_data;
   logic [31:0] pid_bits = 32'h0000_0000;
   logic [31:0] wb_word [8];
   logic got_hit;
   logic fill_slow = 1'b0;
   logic fill_gap = 1'b0;

   dcache_lockdown dcache_lockdown_inst (.clk_in(clk_in), .rst_in(rst_in),
      .cp_valid_in(cp_valid_in), .cp_crn_in(cp_crn_in), .cp_crm_in(cp_crm_in),
      .cp_op2_in(cp_op2_in), .cp_data_in(cp_data_in), .cp_ready_out(cp_ready_out),
      .acc_valid_in(acc_valid_in), .acc_write_in(acc_write_in),
      .acc_cachable_in(acc_cachable_in), .acc_addr_in(acc_addr_in),
      .acc_wdata_in(acc_wdata_in), .acc_done_out(acc_done_out), .acc_hit_out(acc_hit_out),
      .acc_rdata_out(acc_rdata_out), .fill_req_out(fill_req_out),
      .fill_addr_out(fill_addr_out), .fill_valid_in(fill_valid_in),
      .fill_data_in(fill_data_in), .wb_valid_out(wb_valid_out), .wb_addr_out(wb_addr_out),
      .wb_data_out(wb_data_out), .wb_ready_in(wb_ready_in),
      .icache_invalidate_out(icache_invalidate_out),
      .cache_enabled_out(cache_enabled_out), .round_robin_out(round_robin_out));

   initial
   begin
      forever #50 clk_in = ~clk_in;
   end

   function automatic logic [31:0] mem_word(input logic [31:0] a);
      return {a[31:2], 2'b00} ^ 32'h5A5A_0000;
   endfunction : mem_word

   function automatic logic [31:0] b1(input logic x);
      return {31'h0000_0000, x};
   endfunction : b1

   // memory side: words in order, gaps when slow; idle data lines toggle so stale words show
   always @(posedge clk_in)
   begin
      fill_gap <= fill_slow & ~fill_gap;
      if (fill_req_out && fill_cnt < 8 && !fill_gap)
      begin
         fill_valid_in <= 1'b1;
         fill_data_in <= mem_word(fill_addr_out + 32'(fill_cnt * 4));
         fill_cnt <= fill_cnt + 1;
      end
      else
      begin
         fill_valid_in <= 1'b0;
         fill_data_in <= ~fill_data_in;
         if (!fill_req_out)
            fill_cnt <= 0;
      end
      if (fill_valid_in && fill_req_out)
         fill_words <= fill_words + 1;
      if (fill_req_out)
         fill_line <= fill_addr_out;
      // accept every other cycle so write-back is stalled
      wb_ready_in <= wb_valid_out & ~wb_ready_in;
      if (wb_valid_out && wb_ready_in)
      begin
         wb_word[wb_words % 8] <= wb_data_out;
         wb_words <= wb_words + 1;
         wb_line <= wb_addr_out;
      end
      if (icache_invalidate_out)
         ic_pulses <= ic_pulses + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      if (n_fail == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   task automatic timed_out();
      n_fail++;
      $display("wrong value at %0t: wait ran out", $time);
      wrap_up();
   endtask : timed_out

   task automatic cp_write(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
      input logic [31:0] d);
      int i;
      @(posedge clk_in);
      cp_valid_in <= 1'b1;
      cp_crn_in <= crn;
      cp_crm_in <= crm;
      cp_op2_in <= op2;
      cp_data_in <= d;
      for (i = 0; i < 100; i++)
      begin
         @(negedge clk_in);
         if (cp_ready_out === 1'b1)
            break;
      end
      if (i == 100)
         timed_out();
      @(posedge clk_in);
      cp_valid_in <= 1'b0;
      for (i = 0; i < 100; i++)
      begin
         @(negedge clk_in);
         if (cp_ready_out === 1'b1)
            break;
      end
      if (i == 100)
         timed_out();
   endtask : cp_write

   // request held until done is seen, released at the following rising edge
   task automatic access(input logic w, input logic c, input logic [31:0] a, input logic [31:0] d);
      int i;
      int n0;
      n0 = fill_words;
      @(posedge clk_in);
      acc_valid_in <= 1'b1;
      acc_write_in <= w;
      acc_cachable_in <= c;
      acc_addr_in <= a;
      acc_wdata_in <= d;
      for (i = 0; i < 200; i++)
      begin
         @(negedge clk_in);
         if (acc_done_out === 1'b1)
            break;
      end
      if (i == 200)
         timed_out();
      got_hit = acc_hit_out;
      got_data = acc_rdata_out;
      got_fill = fill_words - n0;
      @(posedge clk_in);
      acc_valid_in <= 1'b0;
   endtask : access

   task automatic load(input logic [31:0] a, input logic c, input int fills, input logic hit,
      input logic [31:0] ed);
      logic [31:0] line;
      line = {a[31:5], 5'h00};
      if (a[31:25] == 7'h00)
         line = line | pid_bits;
      access(1'b0, c, a, 32'h0000_0000);
      check(32'(got_fill), 32'(fills));
      check(b1(got_hit), b1(hit));
      if (hit)
         check(got_data, ed);
      if (fills > 0)
         check(fill_line, line);
   endtask : load

   initial
   begin
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      check(b1(cp_ready_out), 32'h0000_0001);
      check({28'h000_0000, fill_req_out, wb_valid_out, cache_enabled_out, round_robin_out},
         32'h0000_0000);
      load(32'h0000_1026, 1'b1, 0, 1'b0, 32'h0000_0000);
      cp_write(dcache_lock_pkg::CRN_CONTROL, 4'h0, 3'h0, 32'h0000_0004);
      check(b1(cache_enabled_out), 32'h0000_0001);
      load(32'h0000_1026, 1'b0, 0, 1'b0, 32'h0000_0000);
      cp_write(dcache_lock_pkg::CRN_LOCKDOWN, 4'h0, 3'h0, 32'h1400_0000);
      load(32'h0000_1026, 1'b1, 8, 1'b1, mem_word(32'h0000_1026));
      load(32'h0000_1026, 1'b1, 0, 1'b1, mem_word(32'h0000_1026));
      access(1'b1, 1'b1, 32'h0000_1028, 32'hC0DE_0001);
      load(32'h0000_1028, 1'b1, 0, 1'b1, 32'hC0DE_0001);
      n = wb_words;
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_CLEAN,
         dcache_lock_pkg::OP2_BY_ADDRESS, 32'h0000_1026);
      check(32'(wb_words - n), 32'h0000_0008);
      check(wb_line, 32'h0000_1020);
      check(wb_word[2], 32'hC0DE_0001);
      check(wb_word[0], mem_word(32'h0000_1020));
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_CLEAN,
         dcache_lock_pkg::OP2_BY_ADDRESS, 32'h0000_1026);
      check(32'(wb_words - n), 32'h0000_0008);
      load(32'h0000_1028, 1'b1, 0, 1'b1, 32'hC0DE_0001);
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_CLEAN_INV,
         dcache_lock_pkg::OP2_BY_ADDRESS, 32'h0000_1026);
      load(32'h0000_1026, 1'b1, 8, 1'b1, mem_word(32'h0000_1026));
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_INVALIDATE,
         dcache_lock_pkg::OP2_BY_ADDRESS, 32'h0000_1026);
      load(32'h0000_1026, 1'b1, 8, 1'b1, mem_word(32'h0000_1026));
      cp_write(dcache_lock_pkg::CRN_CONTROL, 4'h0, 3'h0, 32'h0000_4004);
      check(b1(round_robin_out), 32'h0000_0001);
      fill_slow = 1'b1;
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_INVALIDATE,
         dcache_lock_pkg::OP2_BY_ADDRESS, 32'h0000_2040);
      cp_write(dcache_lock_pkg::CRN_LOCKDOWN, 4'h0, 3'h0, 32'hF800_0000);
      load(32'h0000_2040, 1'b1, 8, 1'b1, mem_word(32'h0000_2040));
      cp_write(dcache_lock_pkg::CRN_LOCKDOWN, 4'h0, 3'h0, 32'hFC00_0000);
      load(32'h0000_3040, 1'b1, 8, 1'b1, mem_word(32'h0000_3040));
      load(32'h0000_4040, 1'b1, 8, 1'b1, mem_word(32'h0000_4040));
      load(32'h0000_2040, 1'b1, 0, 1'b1, mem_word(32'h0000_2040));
      load(32'h0000_3040, 1'b1, 8, 1'b1, mem_word(32'h0000_3040));
      access(1'b1, 1'b1, 32'h0000_3044, 32'hC0DE_0004);
      n = wb_words;
      load(32'h0000_4040, 1'b1, 8, 1'b1, mem_word(32'h0000_4040));
      check(32'(wb_words - n), 32'h0000_0008);
      check(wb_line, 32'h0000_3040);
      check(wb_word[1], 32'hC0DE_0004);
      access(1'b1, 1'b1, 32'h0000_2040, 32'hC0DE_0002);
      n = wb_words;
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_CLEAN,
         dcache_lock_pkg::OP2_BY_INDEX, 32'hF800_0040);
      check(32'(wb_words - n), 32'h0000_0008);
      check(wb_line, 32'h0000_2040);
      check(wb_word[0], 32'hC0DE_0002);
      access(1'b1, 1'b1, 32'h0000_2040, 32'hC0DE_0003);
      n = wb_words;
      for (int s = 0; s < 4; s++)
         for (int i = 0; i < 64; i++)
            cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_CLEAN_INV,
               dcache_lock_pkg::OP2_BY_INDEX, {6'(i), 19'h0_0000, 2'(s), 5'h00});
      check(32'(wb_words - n), 32'h0000_0008);
      check(wb_word[0], 32'hC0DE_0003);
      load(32'h0000_2040, 1'b1, 8, 1'b1, mem_word(32'h0000_2040));
      load(32'h0000_1026, 1'b1, 8, 1'b1, mem_word(32'h0000_1026));
      cp_write(dcache_lock_pkg::CRN_PID, 4'h0, 3'h0, 32'h0200_0000);
      pid_bits = 32'h0200_0000;
      load(32'h0000_5000, 1'b1, 8, 1'b1, mem_word(32'h0200_5000));
      cp_write(dcache_lock_pkg::CRN_PID, 4'h0, 3'h0, 32'h0000_0000);
      pid_bits = 32'h0000_0000;
      load(32'h0200_5000, 1'b1, 0, 1'b1, mem_word(32'h0200_5000));
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_INVALIDATE,
         dcache_lock_pkg::OP2_ALL, 32'h0000_0000);
      load(32'h0200_5000, 1'b1, 8, 1'b1, mem_word(32'h0200_5000));
      n = ic_pulses;
      cp_write(dcache_lock_pkg::CRN_CACHE_OP, dcache_lock_pkg::CRM_ICACHE_INV,
         dcache_lock_pkg::OP2_ALL, 32'h0000_0000);
      repeat (2) @(negedge clk_in);
      check(32'(ic_pulses - n), 32'h0000_0001);
      wrap_up();
   end
endmodule : dcache_lockdown_tb

// ### verilog/dcache_lock_pkg.sv
// constants and types for the data cache lockdown and maintenance block
package dcache_lock_pkg;
   // geometry
   localparam int SEGMENTS = 4;
   localparam int LINES = 64;
   localparam int LINE_WORDS = 8;
   localparam logic [5:0] LAST_INDEX = 6'h3F;
   localparam logic [2:0] LAST_WORD = 3'h7;
   // address fields of the modified virtual address
   localparam int SEG_MSB = 6;
   localparam int SEG_LSB = 5;
   localparam int WORD_MSB = 4;
   localparam int WORD_LSB = 2;
   localparam int TAG_LSB = 7;
   localparam int TAG_WIDTH = 25;
   localparam int PID_LSB = 25;
   localparam int PID_WIDTH = 7;
   // coprocessor register numbers and operation codes
   localparam logic [3:0] CRN_CONTROL = 4'h1;
   localparam logic [3:0] CRN_CACHE_OP = 4'h7;
   localparam logic [3:0] CRN_LOCKDOWN = 4'h9;
   localparam logic [3:0] CRN_PID = 4'hD;
   localparam logic [3:0] CRM_ICACHE_INV = 4'h5;
   localparam logic [3:0] CRM_INVALIDATE = 4'h6;
   localparam logic [3:0] CRM_CLEAN = 4'hA;
   localparam logic [3:0] CRM_CLEAN_INV = 4'hE;
   localparam logic [2:0] OP2_ALL = 3'h0;
   localparam logic [2:0] OP2_BY_ADDRESS = 3'h1;
   localparam logic [2:0] OP2_BY_INDEX = 3'h2;
   // control register bits and lockdown operand field
   localparam int ROUND_ROBIN_BIT = 14;
   localparam int DCACHE_ENABLE_BIT = 2;
   localparam int VICTIM_LSB = 26;
   // reset values
   localparam logic [5:0] VICTIM_RESET = 6'h00;
   localparam logic RR_RESET = 1'b0;
   localparam logic ENABLE_RESET = 1'b0;
   // pipeline depth of the core ahead of execution
   localparam int PREFETCH_DEPTH = 3;

   typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_WRITEBACK} state_type;
endpackage : dcache_lock_pkg

// ### verilog/dcache_lockdown.sv
// data cache with lookup, linefill, lockable victim pointer and maintenance ops
`timescale 1ns/1ps
module dcache_lockdown #(
   parameter logic [5:0] RANDOM_SEED = 6'h2D
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // coprocessor register writes
   input wire logic cp_valid_in,
   input wire logic [3:0] cp_crn_in,
   input wire logic [3:0] cp_crm_in,
   input wire logic [2:0] cp_op2_in,
   input wire logic [31:0] cp_data_in,
   output logic cp_ready_out,
   // core data accesses
   input wire logic acc_valid_in,
   input wire logic acc_write_in,
   input wire logic acc_cachable_in,
   input wire logic [31:0] acc_addr_in,
   input wire logic [31:0] acc_wdata_in,
   output logic acc_done_out,
   output logic acc_hit_out,
   output logic [31:0] acc_rdata_out,
   // linefill from memory
   output logic fill_req_out,
   output logic [31:0] fill_addr_out,
   input wire logic fill_valid_in,
   input wire logic [31:0] fill_data_in,
   // write-back to memory
   output logic wb_valid_out,
   output logic [31:0] wb_addr_out,
   output logic [31:0] wb_data_out,
   input wire logic wb_ready_in,
   // status
   output logic icache_invalidate_out,
   output logic cache_enabled_out,
   output logic round_robin_out
);
   initial
   begin
      if (RANDOM_SEED == 6'h00)
         $error("RANDOM_SEED must be nonzero");
   end

   // tag, valid and dirty live in flops so a whole segment compares at once
   logic [3:0][63:0][24:0] tag_mem;
   logic [3:0][63:0] valid;
   logic [3:0][63:0] dirty;
   logic [31:0] data_mem [0:2047];

   dcache_lock_pkg::state_type state, next_state;
   logic [2:0] word_cnt, next_word_cnt;
   logic [1:0] seg, next_seg;
   logic [5:0] idx, next_idx;
   logic [24:0] fill_tag, next_fill_tag;
   logic ret_fill, next_ret_fill;
   logic inv_after, next_inv_after;
   logic [3:0][5:0] vptr, next_vptr;
   logic [5:0] base, next_base;
   logic rr, next_rr;
   logic en, next_en;
   logic [6:0] pid, next_pid;
   logic [5:0] lfsr, next_lfsr;
   logic done, next_done;
   logic hit_q, next_hit_q;
   logic [31:0] rdata, next_rdata;
   logic [31:0] wb_data, next_wb_data;
   logic icinv, next_icinv;
   // array write enables
   logic inv_all, clr_valid, clr_dirty, fill_we, tag_set, st_we;
   // lookup
   logic [31:0] modified_virtual_address;
   logic [1:0] look_seg;
   logic [6:0] look;
   logic [5:0] rand_idx;
   logic [5:0] victim;

   // pid remaps only the lowest 32MB of core addresses
   function automatic logic [31:0] remap(input logic [31:0] va, input logic [6:0] p);
      remap = (va[31:25] == 7'h00) ? {p, va[24:0]} : va;
   endfunction : remap

   // fully associative compare within one segment: {hit, index}
   function automatic logic [6:0] find(input logic [63:0][24:0] tags,
                                       input logic [63:0] vld, input logic [24:0] t);
      find = 7'h00;
      for (int i = 0; i < 64; i++)
      begin
         if (vld[i] && tags[i] == t)
            find = {1'b1, 6'(i)};
      end
   endfunction : find

   function automatic logic [10:0] word_addr(input logic [1:0] s, input logic [5:0] i,
                                             input logic [2:0] w);
      word_addr = {s, i, w};
   endfunction : word_addr

   always_comb
   begin
      modified_virtual_address = remap(cp_valid_in ? cp_data_in : acc_addr_in, pid);
      look_seg = modified_virtual_address[dcache_lock_pkg::SEG_MSB:dcache_lock_pkg::SEG_LSB];
      look = find(tag_mem[look_seg], valid[look_seg],
                  modified_virtual_address[31:dcache_lock_pkg::TAG_LSB]);
      // random victim never falls below the locked region
      rand_idx = (lfsr < base) ? base : lfsr;
      victim = rr ? vptr[look_seg] : rand_idx;
   end

   always_comb
   begin
      next_state = state;
      next_word_cnt = word_cnt;
      next_seg = seg;
      next_idx = idx;
      next_fill_tag = fill_tag;
      next_ret_fill = ret_fill;
      next_inv_after = inv_after;
      next_vptr = vptr;
      next_base = base;
      next_rr = rr;
      next_en = en;
      next_pid = pid;
      next_lfsr = {lfsr[4:0], lfsr[5] ^ lfsr[4]};
      next_done = 1'b0;
      next_hit_q = 1'b0;
      next_rdata = rdata;
      next_wb_data = wb_data;
      next_icinv = 1'b0;
      inv_all = 1'b0;
      clr_valid = 1'b0;
      clr_dirty = 1'b0;
      fill_we = 1'b0;
      tag_set = 1'b0;
      st_we = 1'b0;
      case (state)
         dcache_lock_pkg::ST_IDLE:
         begin
            if (cp_valid_in)
            begin
               case (cp_crn_in)
                  dcache_lock_pkg::CRN_CONTROL:
                  begin
                     next_rr = cp_data_in[dcache_lock_pkg::ROUND_ROBIN_BIT];
                     next_en = cp_data_in[dcache_lock_pkg::DCACHE_ENABLE_BIT];
                  end
                  dcache_lock_pkg::CRN_LOCKDOWN:
                  begin
                     next_base = cp_data_in[31:dcache_lock_pkg::VICTIM_LSB];
                     for (int s = 0; s < 4; s++)
                        next_vptr[s] = cp_data_in[31:dcache_lock_pkg::VICTIM_LSB];
                  end
                  dcache_lock_pkg::CRN_PID:
                     next_pid = cp_data_in[31:dcache_lock_pkg::PID_LSB];
                  dcache_lock_pkg::CRN_CACHE_OP:
                  begin
                     next_seg = look_seg;
                     next_idx = look[5:0];
                     if (cp_op2_in == dcache_lock_pkg::OP2_BY_INDEX)
                        next_idx = cp_data_in[31:dcache_lock_pkg::VICTIM_LSB];
                     if (cp_crm_in == dcache_lock_pkg::CRM_INVALIDATE)
                     begin
                        if (cp_op2_in == dcache_lock_pkg::OP2_ALL)
                           inv_all = 1'b1;
                        else if (cp_op2_in == dcache_lock_pkg::OP2_BY_ADDRESS)
                           clr_valid = look[6];
                     end
                     else if ((cp_crm_in == dcache_lock_pkg::CRM_CLEAN ||
                               cp_crm_in == dcache_lock_pkg::CRM_CLEAN_INV) &&
                              (cp_op2_in == dcache_lock_pkg::OP2_BY_ADDRESS ||
                               cp_op2_in == dcache_lock_pkg::OP2_BY_INDEX))
                     begin
                        next_inv_after = (cp_crm_in == dcache_lock_pkg::CRM_CLEAN_INV);
                        next_ret_fill = 1'b0;
                        if (valid[look_seg][next_idx] && (look[6] ||
                            cp_op2_in == dcache_lock_pkg::OP2_BY_INDEX))
                        begin
                           if (dirty[look_seg][next_idx])
                           begin
                              next_state = dcache_lock_pkg::ST_WRITEBACK;
                              next_word_cnt = 3'h0;
                              next_wb_data = data_mem[word_addr(look_seg, next_idx, 3'h0)];
                           end
                           else
                              clr_valid = next_inv_after;
                        end
                     end
                     else if (cp_crm_in == dcache_lock_pkg::CRM_ICACHE_INV &&
                              cp_op2_in == dcache_lock_pkg::OP2_ALL)
                        next_icinv = 1'b1;
                  end
                  default:
                  begin
                     next_en = en;
                  end
               endcase
            end
            // a held request is not taken again while its done pulse stands
            else if (acc_valid_in && !done)
            begin
               next_seg = look_seg;
               next_idx = look[5:0];
               // no snooping: only the core's own accesses touch the arrays
               if (!en || (!look[6] && (acc_write_in || !acc_cachable_in)))
                  next_done = 1'b1;
               else if (look[6])
               begin
                  next_done = 1'b1;
                  next_hit_q = 1'b1;
                  if (acc_write_in)
                     st_we = 1'b1;
                  else
                     next_rdata = data_mem[word_addr(look_seg, look[5:0],
                        modified_virtual_address[dcache_lock_pkg::WORD_MSB:dcache_lock_pkg::WORD_LSB])];
               end
               else
               begin
                  // any alignment: low address bits only pick the word
                  next_idx = victim;
                  next_fill_tag = modified_virtual_address[31:dcache_lock_pkg::TAG_LSB];
                  next_word_cnt = 3'h0;
                  if (valid[look_seg][victim] && dirty[look_seg][victim])
                  begin
                     next_ret_fill = 1'b1;
                     next_inv_after = 1'b0;
                     next_state = dcache_lock_pkg::ST_WRITEBACK;
                     next_wb_data = data_mem[word_addr(look_seg, victim, 3'h0)];
                  end
                  else
                     next_state = dcache_lock_pkg::ST_FILL;
               end
            end
         end
         dcache_lock_pkg::ST_FILL:
         begin
            if (fill_valid_in)
            begin
               fill_we = 1'b1;
               next_word_cnt = word_cnt + 3'h1;
               if (word_cnt == dcache_lock_pkg::LAST_WORD)
               begin
                  tag_set = 1'b1;
                  next_vptr[seg] = (vptr[seg] == dcache_lock_pkg::LAST_INDEX) ?
                                   base : vptr[seg] + 6'h01;
                  next_state = dcache_lock_pkg::ST_IDLE;
               end
            end
         end
         dcache_lock_pkg::ST_WRITEBACK:
         begin
            if (wb_ready_in)
            begin
               next_word_cnt = word_cnt + 3'h1;
               next_wb_data = data_mem[word_addr(seg, idx, word_cnt + 3'h1)];
               if (word_cnt == dcache_lock_pkg::LAST_WORD)
               begin
                  clr_dirty = 1'b1;
                  clr_valid = inv_after;
                  next_state = ret_fill ? dcache_lock_pkg::ST_FILL : dcache_lock_pkg::ST_IDLE;
               end
            end
         end
         default:
            next_state = dcache_lock_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state <= dcache_lock_pkg::ST_IDLE;
         word_cnt <= 3'h0;
         seg <= 2'h0;
         idx <= 6'h00;
         fill_tag <= 25'h000_0000;
         ret_fill <= 1'b0;
         inv_after <= 1'b0;
         vptr <= {4{dcache_lock_pkg::VICTIM_RESET}};
         base <= dcache_lock_pkg::VICTIM_RESET;
         rr <= dcache_lock_pkg::RR_RESET;
         en <= dcache_lock_pkg::ENABLE_RESET;
         pid <= 7'h00;
         lfsr <= RANDOM_SEED;
         done <= 1'b0;
         hit_q <= 1'b0;
         rdata <= 32'h0000_0000;
         wb_data <= 32'h0000_0000;
         icinv <= 1'b0;
      end
      else
      begin
         state <= next_state;
         word_cnt <= next_word_cnt;
         seg <= next_seg;
         idx <= next_idx;
         fill_tag <= next_fill_tag;
         ret_fill <= next_ret_fill;
         inv_after <= next_inv_after;
         vptr <= next_vptr;
         base <= next_base;
         rr <= next_rr;
         en <= next_en;
         pid <= next_pid;
         lfsr <= next_lfsr;
         done <= next_done;
         hit_q <= next_hit_q;
         rdata <= next_rdata;
         wb_data <= next_wb_data;
         icinv <= next_icinv;
      end
   end

   // arrays: tags and data need no reset, valid and dirty do
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         valid <= '0;
         dirty <= '0;
      end
      else
      begin
         if (inv_all)
            valid <= '0;
         if (clr_valid)
            valid[next_seg][next_idx] <= 1'b0;
         if (clr_dirty)
            dirty[seg][idx] <= 1'b0;
         if (st_we)
            dirty[look_seg][look[5:0]] <= 1'b1;
         if (tag_set)
         begin
            tag_mem[seg][idx] <= fill_tag;
            valid[seg][idx] <= 1'b1;
            dirty[seg][idx] <= 1'b0;
         end
      end
      if (fill_we)
         data_mem[word_addr(seg, idx, word_cnt)] <= fill_data_in;
      if (st_we)
         data_mem[word_addr(look_seg, look[5:0],
            modified_virtual_address[dcache_lock_pkg::WORD_MSB:dcache_lock_pkg::WORD_LSB])] <= acc_wdata_in;
   end

   assign cp_ready_out = (state == dcache_lock_pkg::ST_IDLE);
   assign acc_done_out = done;
   assign acc_hit_out = hit_q;
   assign acc_rdata_out = rdata;
   assign fill_req_out = (state == dcache_lock_pkg::ST_FILL);
   assign fill_addr_out = {fill_tag, seg, 5'h00};
   assign wb_valid_out = (state == dcache_lock_pkg::ST_WRITEBACK);
   assign wb_addr_out = {tag_mem[seg][idx], seg, 5'h00};
   assign wb_data_out = wb_data;
   assign icache_invalidate_out = icinv;
   assign cache_enabled_out = en;
   assign round_robin_out = rr;

   // assertions
   logic idle_acc;
   logic cp_op;
   assign idle_acc = (state == dcache_lock_pkg::ST_IDLE) && !cp_valid_in && acc_valid_in && !done;
   assign cp_op = (state == dcache_lock_pkg::ST_IDLE) && cp_valid_in;

   sequence s_fill_start;
      idle_acc && en && !look[6] && !acc_write_in && acc_cachable_in;
   endsequence
   sequence s_last_fill_word;
      state == dcache_lock_pkg::ST_FILL && fill_valid_in && word_cnt == 3'h7;
   endsequence

   a_disabled_no_lookup: assert property (@(posedge clk_in) disable iff (rst_in)
      idle_acc && !en |=> acc_done_out && !acc_hit_out && !fill_req_out)
      else $error("disabled cache looked up");
   a_fill_eight_words: assert property (@(posedge clk_in) disable iff (rst_in)
      s_last_fill_word |=> state == dcache_lock_pkg::ST_IDLE && valid[$past(seg)][$past(idx)])
      else $error("linefill did not complete after eight words");
   a_fill_above_base: assert property (@(posedge clk_in) disable iff (rst_in)
      s_fill_start |=> idx >= base)
      else $error("victim below lockdown base");
   a_lockdown_write: assert property (@(posedge clk_in) disable iff (rst_in)
      cp_op && cp_crn_in == 4'h9 |=> vptr[0] == $past(cp_data_in[31:26])
                                     && base == $past(cp_data_in[31:26]))
      else $error("lockdown write not taken");
   a_invalidate_all: assert property (@(posedge clk_in) disable iff (rst_in)
      cp_op && cp_crn_in == 4'h7 && cp_crm_in == 4'h6 && cp_op2_in == 3'h0 |=> valid == '0)
      else $error("invalidate all left valid lines");
   a_clean_dirty_wb: assert property (@(posedge clk_in) disable iff (rst_in)
      cp_op && cp_crn_in == 4'h7 && cp_crm_in == 4'hA && cp_op2_in == 3'h2
      && dirty[cp_data_in[6:5]][cp_data_in[31:26]] && valid[cp_data_in[6:5]][cp_data_in[31:26]]
      |=> wb_valid_out [*1])
      else $error("clean of dirty line did not write back");
   a_pid_keeps_cache: assert property (@(posedge clk_in) disable iff (rst_in)
      cp_op && cp_crn_in == 4'hD |=> valid == $past(valid) && dirty == $past(dirty))
      else $error("pid write changed cache state");
   a_store_dirty: assert property (@(posedge clk_in) disable iff (rst_in)
      idle_acc && en && look[6] && acc_write_in |=> dirty[$past(look_seg)][$past(look[5:0])])
      else $error("store hit left line clean");
   a_victim_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_last_fill_word and (vptr[seg] == 6'h3F)) |=> vptr[$past(seg)] == base)
      else $error("victim pointer did not wrap to base");
endmodule : dcache_lockdown
